//--- src/udb_defs.svh
// constants for the uart data buffer and baud timer block
// assumes a 32-bit classic wishbone slave, byte addressed
`ifndef UDB_DEFS_SVH
`define UDB_DEFS_SVH
`define UDB_IDX_DATA      8'h99
`define UDB_IDX_CTRL      8'h9A
`define UDB_IDX_RELOAD    8'h9B
`define UDB_IDX_STATUS    8'h9C
`define UDB_DATA_RST      8'h00
`define UDB_RELOAD_RST    8'h00
`define UDB_PS_SYS12      2'h0
`define UDB_PS_SYS4       2'h1
`define UDB_PS_SYS48      2'h2
`define UDB_PS_EXT8       2'h3
`define UDB_DIV12         6'h0C
`define UDB_DIV4          6'h04
`define UDB_DIV48         6'h30
`define UDB_DIV8          6'h08
`define UDB_CTRL_PS_LO    0
`define UDB_CTRL_DIRECT   2
`define UDB_FRAME_BITS    4'hA
`define UDB_TMR_MAX       8'hFF
`endif

//--- src/udb_pkg.sv
// types for the uart data buffer and baud timer block
// assumes udb_defs.svh supplies the numeric constants
package udb_pkg;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } udb_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } udb_wb_rsp_t;

  typedef enum logic [1:0] {
    UDB_RX_IDLE,
    UDB_RX_DATA,
    UDB_RX_STOP
  } udb_rx_state_t;

  typedef struct packed {
    logic [7:0]    tx_shift;
    logic [3:0]    tx_bits;
    logic          tx_busy;
    logic          tx_line;
    logic          tx_done;
    logic [7:0]    rx_latch;
    logic [7:0]    rx_shift;
    logic [3:0]    rx_bits;
    logic          rx_full;
    logic          rx_sync;
    udb_rx_state_t rx_state;
    logic [1:0]    prescale_sel;
    logic          direct_sel;
    logic [7:0]    reload;
    logic [7:0]    timer;
    logic [5:0]    pre_cnt;
    logic          ext_sync1;
    logic          ext_sync2;
    logic          ext_last;
    logic          half_tick;
    logic          tx_phase;
    logic [4:0]    rx_phase;
    logic          ack;
    logic [31:0]   rdat;
  } udb_state_t;
endpackage

//--- src/udb_top.sv
// uart data buffer with baud timer behind a wishbone slave
// assumes synchronous inputs except ext_osc_clk_i, which is synchronised here
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "udb_defs.svh"

module udb_top (
  input  wire logic                clk_i,         // system clock
  input  wire logic                rst_i,         // synchronous reset, high
  input  wire udb_pkg::udb_wb_req_t wb_req_i,     // wishbone request
  output udb_pkg::udb_wb_rsp_t     wb_rsp_o,      // wishbone answer
  input  wire logic                ext_osc_clk_i, // external oscillator clock
  input  wire logic                rxd_i,         // serial receive line
  output logic                     txd_o,         // serial transmit line
  output logic                     tx_busy_o      // frame in flight
);
  import udb_pkg::*;

  udb_state_t s_q;
  udb_state_t s_d;

  // word index from byte address
  function automatic logic [7:0] word_idx(input logic [31:0] a);
    word_idx = a[9:2];
  endfunction

  // timer clock divide for a prescale code
  function automatic logic [5:0] ps_div(input logic [1:0] c);
    case (c)
      `UDB_PS_SYS12: ps_div = `UDB_DIV12;
      `UDB_PS_SYS4:  ps_div = `UDB_DIV4;
      `UDB_PS_SYS48: ps_div = `UDB_DIV48;
      default:       ps_div = `UDB_DIV8;
    endcase
  endfunction

  logic       wr_hit;
  logic       rd_hit;
  logic [7:0] idx;
  logic       tmr_tick;
  logic       ovf;
  logic       ext_rise;

  // ******************************************************
  // next state
  // ******************************************************
  always_comb begin
    s_d = s_q;
    idx = word_idx(wb_req_i.adr);
    wr_hit = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !s_q.ack;
    rd_hit = wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && !s_q.ack;
    ext_rise = s_q.ext_sync2 && !s_q.ext_last;
    tmr_tick = 1'b0;
    ovf = 1'b0;

    s_d.ext_sync1 = ext_osc_clk_i;
    s_d.ext_sync2 = s_q.ext_sync1;
    s_d.ext_last = s_q.ext_sync2;

    // timer clock selection
    if (s_q.direct_sel) begin
      tmr_tick = 1'b1;
    end else if (s_q.prescale_sel == `UDB_PS_EXT8) begin
      if (ext_rise) begin
        if (s_q.pre_cnt >= ps_div(s_q.prescale_sel) - 6'h01) begin
          s_d.pre_cnt = 6'h00;
          tmr_tick = 1'b1;
        end else begin
          s_d.pre_cnt = s_q.pre_cnt + 6'h01;
        end
      end
    end else begin
      if (s_q.pre_cnt >= ps_div(s_q.prescale_sel) - 6'h01) begin
        s_d.pre_cnt = 6'h00;
        tmr_tick = 1'b1;
      end else begin
        s_d.pre_cnt = s_q.pre_cnt + 6'h01;
      end
    end

    // auto-reload timer; two overflows per bit
    if (tmr_tick) begin
      if (s_q.timer == `UDB_TMR_MAX) begin
        s_d.timer = s_q.reload;
        ovf = 1'b1;
      end else begin
        s_d.timer = s_q.timer + 8'h01;
      end
    end
    s_d.half_tick = ovf;

    // transmitter: start, 8 data lsb first, stop
    s_d.tx_done = 1'b0;
    if (s_q.tx_busy && s_q.half_tick) begin
      s_d.tx_phase = !s_q.tx_phase;
      if (s_q.tx_phase) begin
        if (s_q.tx_bits == `UDB_FRAME_BITS - 4'h1) begin
          s_d.tx_busy = 1'b0;
          s_d.tx_line = 1'b1;
          s_d.tx_done = 1'b1;
        end else if (s_q.tx_bits == `UDB_FRAME_BITS - 4'h2) begin
          s_d.tx_line = 1'b1;
          s_d.tx_bits = s_q.tx_bits + 4'h1;
        end else begin
          s_d.tx_line = s_q.tx_shift[s_q.tx_bits[2:0]];
          s_d.tx_bits = s_q.tx_bits + 4'h1;
        end
      end
    end

    // receiver: two half ticks per bit, sample at centre
    s_d.rx_sync = rxd_i;
    if (s_q.half_tick) begin
      case (s_q.rx_state)
        UDB_RX_IDLE: begin
          if (!s_q.rx_sync) begin
            s_d.rx_state = UDB_RX_DATA;
            s_d.rx_phase = 5'h00;
            s_d.rx_bits = 4'h0;
          end
        end
        UDB_RX_DATA: begin
          s_d.rx_phase = s_q.rx_phase + 5'h01;
          // even half ticks land mid-bit: the first one falls inside the start bit
          if (!s_q.rx_phase[0]) begin
            if (s_q.rx_bits == 4'h0 && s_q.rx_sync) begin
              s_d.rx_state = UDB_RX_IDLE;
            end else begin
              if (s_q.rx_bits != 4'h0) begin
                s_d.rx_shift = {s_q.rx_sync, s_q.rx_shift[7:1]};
              end
              s_d.rx_bits = s_q.rx_bits + 4'h1;
              if (s_q.rx_bits == `UDB_FRAME_BITS - 4'h2) begin
                s_d.rx_state = UDB_RX_STOP;
              end
            end
          end
        end
        UDB_RX_STOP: begin
          s_d.rx_phase = s_q.rx_phase + 5'h01;
          if (!s_q.rx_phase[0]) begin
            if (s_q.rx_sync && !s_q.rx_full) begin
              s_d.rx_latch = s_q.rx_shift;
              s_d.rx_full = 1'b1;
            end
            s_d.rx_state = UDB_RX_IDLE;
          end
        end
        default: s_d.rx_state = UDB_RX_IDLE;
      endcase
    end

    // bus slave, one wait state, ack for one cycle
    s_d.ack = wr_hit || rd_hit;
    s_d.rdat = 32'h0000_0000;
    if (wr_hit && wb_req_i.sel[0]) begin
      case (idx)
        `UDB_IDX_DATA: begin
          s_d.tx_shift = wb_req_i.dat[7:0];
          s_d.tx_busy = 1'b1;
          s_d.tx_bits = 4'h0;
          s_d.tx_phase = 1'b0;
          s_d.tx_line = 1'b0;
        end
        `UDB_IDX_CTRL: begin
          s_d.prescale_sel = wb_req_i.dat[`UDB_CTRL_PS_LO +: 2];
          s_d.direct_sel = wb_req_i.dat[`UDB_CTRL_DIRECT];
          s_d.pre_cnt = 6'h00;
        end
        `UDB_IDX_RELOAD: begin
          s_d.reload = wb_req_i.dat[7:0];
          s_d.timer = wb_req_i.dat[7:0];
        end
        `UDB_IDX_STATUS: begin
          // a latch load in this cycle beats the clear
          if (wb_req_i.dat[1] && !(s_q.half_tick && s_q.rx_state == UDB_RX_STOP)) begin
            s_d.rx_full = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (rd_hit) begin
      case (idx)
        `UDB_IDX_DATA:   s_d.rdat = {24'h000000, s_q.rx_latch};
        `UDB_IDX_CTRL:   s_d.rdat = {29'h0, s_q.direct_sel, s_q.prescale_sel};
        `UDB_IDX_RELOAD: s_d.rdat = {24'h000000, s_q.reload};
        `UDB_IDX_STATUS: s_d.rdat = {30'h0, s_q.rx_full, s_q.tx_busy};
        default:         s_d.rdat = 32'h0000_0000;
      endcase
    end
  end

  // ******************************************************
  // state register
  // ******************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.tx_shift <= `UDB_DATA_RST;
      s_q.rx_latch <= `UDB_DATA_RST;
      s_q.reload <= `UDB_RELOAD_RST;
      s_q.tx_line <= 1'b1;
      s_q.rx_sync <= 1'b1;
      s_q.rx_state <= UDB_RX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_rsp_o.ack = s_q.ack;
  assign wb_rsp_o.dat = s_q.rdat;
  assign txd_o = s_q.tx_line;
  assign tx_busy_o = s_q.tx_busy;
endmodule // udb_top
`default_nettype wire

//--- verif/udb_properties.sv
// port checker for udb_top
// assumes a bind to udb_top
`timescale 1ns/10ps
`default_nettype none
module udb_properties (
  input wire logic                 clk_i,         // clock
  input wire logic                 rst_i,         // reset
  input wire udb_pkg::udb_wb_req_t wb_req_i,      // request
  input wire udb_pkg::udb_wb_rsp_t wb_rsp_o,      // answer
  input wire logic                 ext_osc_clk_i, // ext clock
  input wire logic                 rxd_i,         // rx line
  input wire logic                 txd_o,         // tx line
  input wire logic                 tx_busy_o      // busy
);
  import udb_pkg::*;
  // ****
  // bus and frame checks
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic tk = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  wire logic wd = tk && wb_req_i.we && wb_req_i.adr == 32'h264;
  ack_follows_a: assert property (tk |=> wb_rsp_o.ack)
    else $error("no ack");
  ack_single_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("long ack");
  dat_idle_a: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0)
    else $error("dat idle");
  byte_wide_a: assert property (
    wb_rsp_o.ack |-> wb_rsp_o.dat[31:8] == 24'h0) else $error("wide");
  write_starts_a: assert property (
    wd && wb_req_i.sel[0] |=> tx_busy_o && !txd_o) else $error("no start");
  sel_ignored_a: assert property (
    wd && !wb_req_i.sel[0] && !tx_busy_o |=> !tx_busy_o) else $error("sel");
  frame_hold_a: assert property ($rose(tx_busy_o) |=> tx_busy_o [*8])
    else $error("short frame");
  idle_high_a: assert property (!tx_busy_o |-> txd_o)
    else $error("line low");
endmodule // udb_properties
bind udb_top udb_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .ext_osc_clk_i(ext_osc_clk_i),
  .rxd_i(rxd_i), .txd_o(txd_o), .tx_busy_o(tx_busy_o));
`default_nettype wire

//--- verif/udb_far_model.sv
// remote serial device, 8N1 frames
// assumes bit length given in clocks
`timescale 1ns/10ps
`default_nettype none
module udb_far_model (
  input wire logic clk_i, // clock
  input wire logic txd_i, // from block
  output var logic rxd_o  // to block
);
  // ****
  // frame tasks
  // ****
  initial rxd_o = 1'b1;
  // samples a quarter into each bit, safe if the start bit is short
  task automatic recv(input int b, output logic [8:0] v);
    while (txd_i !== 1'b0) @(posedge clk_i);
    repeat (b / 4) @(posedge clk_i);
    for (int k = 0; k < 9; k++) begin
      repeat (b) @(posedge clk_i);
      v[k] = txd_i;
    end
  endtask
  task automatic send(input int b, input logic [7:0] d);
    for (int k = 0; k < 10; k++) begin
      rxd_o <= k == 0 ? 1'b0 : k == 9 ? 1'b1 : d[k-1];
      repeat (b) @(posedge clk_i);
    end
  endtask
endmodule // udb_far_model
`default_nettype wire

//--- verif/tb_top.sv
// bench for udb_top
// assumes udb_far_model on the lines
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import udb_pkg::*;
  localparam logic [7:0] RLD = 8'hF8;
  logic        clk_i, rst_i, txd_o, tx_busy_o, rxd_i;
  logic [2:0]  ec;
  udb_wb_req_t req;
  udb_wb_rsp_t rsp;
  int          err_count, n_checks;
  udb_top u_udb_top (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_rsp_o(rsp), .ext_osc_clk_i(ec[2]), .rxd_i(rxd_i), .txd_o(txd_o),
    .tx_busy_o(tx_busy_o));
  udb_far_model u_udb_far_model (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));
  // ****
  // clock, tasks
  // ****
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) ec <= ec + 3'h1;
  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, s, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 64);
    q = rsp.dat;
    if (n >= 64) err_count++;
    req <= '0;
    @(posedge clk_i);
  endtask
  // ext clock period 8 clocks, over 8 gives 64
  function automatic int bclk(logic dr, logic [1:0] ps);
    int dv;
    dv = dr ? 1 : ps == 2'h0 ? 12 : ps == 2'h1 ? 4 : ps == 2'h2 ? 48 : 64;
    return 2 * (256 - int'(RLD)) * dv;
  endfunction
  // ****
  // tests
  // ****
  initial begin
    logic [31:0] q;
    logic [8:0]  v;
    logic [7:0]  tx;
    logic [1:0]  ps;
    logic        dr;
    int          b;
    void'($urandom(24693));
    req = '0;
    rst_i = 1'b1;
    ec = 3'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 32'h264, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    wb(1'b1, 32'h300, 32'hFF, 4'hF, q);
    wb(1'b0, 32'h300, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    wb(1'b1, 32'h264, 32'h5A, 4'hE, q);
    chk(32'(tx_busy_o), 32'h0);
    for (int i = 0; i < 5; i++) begin
      dr = i == 0;
      ps = dr ? 2'($urandom) : 2'(i - 1);
      b = bclk(dr, ps);
      tx = 8'($urandom);
      wb(1'b1, 32'h268, {29'h0, dr, ps}, 4'hF, q);
      wb(1'b1, 32'h26C, {24'h0, RLD}, 4'hF, q);
      fork
        wb(1'b1, 32'h264, {24'h0, tx}, 4'h1, q);
        u_udb_far_model.recv(b, v);
      join
      chk(32'(v), {23'h0, 1'b1, tx});
      u_udb_far_model.send(b, ~tx);
      repeat (b) @(posedge clk_i);
      wb(1'b0, 32'h264, 32'h0, 4'hF, q);
      chk(q, {24'h0, ~tx});
      wb(1'b1, 32'h270, 32'h2, 4'hF, q);
    end
    results;
  end
  initial begin
    #1000000;
    err_count++;
    results;
  end
endmodule // tb_top
`default_nettype wire
